// ---- src/rpp_map.svh ----
// timing counts, field positions and codes for the prom programming link
`ifndef RPP_MAP_SVH
`define RPP_MAP_SVH
`define RPP_CLK_HZ          20000000
`define RPP_PULSE_US        200
`define RPP_ARCH_PULSE_US   10000
`define RPP_LAST_PULSE_US   8000
`define RPP_MAX_PULSE_US    10000
`define RPP_SETTLE_US       1
`define RPP_PULSE_CYC       ((`RPP_PULSE_US * (`RPP_CLK_HZ / 1000000)))
`define RPP_ARCH_CYC        ((`RPP_ARCH_PULSE_US * (`RPP_CLK_HZ / 1000000)))
`define RPP_LAST_CYC        ((`RPP_LAST_PULSE_US * (`RPP_CLK_HZ / 1000000)))
`define RPP_SETTLE_CYC      ((`RPP_SETTLE_US * (`RPP_CLK_HZ / 1000000)))
`define RPP_OVER_MULT       4
`define RPP_MAX_TRIES       10
`define RPP_ARCH_ASYNC_OE   8'h00
`define RPP_ARCH_SYNC_OE    8'h01
`define RPP_ARCH_ASYNC_INIT 8'h02
`define RPP_ERASED_BYTE     8'h00
`define RPP_REG_CTRL        32'h0000_0000
`define RPP_REG_STATUS      32'h0000_0004
`define RPP_REG_ADDR        32'h0000_0008
`define RPP_REG_DATA        32'h0000_000c
`define RPP_REG_LAST        32'h0000_0010
`define RPP_CTRL_START      0
`define RPP_CTRL_ARCH       1
`define RPP_CTRL_SUPPLY     2
`define RPP_CTRL_CHECK      3
`define RPP_ST_BUSY         0
`define RPP_ST_PASS         1
`define RPP_ST_REJECT       2
`define RPP_ST_CFG_OE       3
`endif

// ---- src/rpp_pkg.sv ----
// types shared by both ends of the prom programming link
package rpp_pkg;
  typedef enum logic [1:0] {
    RPP_ARCH_ASYNC_EN,
    RPP_ARCH_SYNC_EN,
    RPP_ARCH_ASYNC_INIT
  } rpp_arch_e;
endpackage : rpp_pkg

// ---- src/rpp_link_if.sv ----
// pin-level link between the prom and its programmer
`timescale 1ns/10ps
`default_nettype none
interface rpp_link_if #(parameter int AW = 13);
  logic          supervoltage;
  logic          arch_supervoltage;
  logic [AW-1:0] address;
  logic [7:0]    prog_data;
  logic          prog_data_oe;
  logic [7:0]    dev_data;
  logic          dev_data_oe;
  logic          program_strobe_n;
  logic          verify_strobe_n;
  logic          enable_init_n;
  logic          pclk;
  logic          diagnostic_mode_select;
  logic          diagnostic_shift_clock;
  logic          shadow_serial_input;
  logic          shadow_serial_output;
  logic          shadow_to_pipe;
  modport prom (input supervoltage, arch_supervoltage, address, prog_data, prog_data_oe,
    program_strobe_n, verify_strobe_n, enable_init_n, pclk, diagnostic_mode_select,
    diagnostic_shift_clock, shadow_serial_input, shadow_to_pipe,
    output dev_data, dev_data_oe, shadow_serial_output);
  modport prog (output supervoltage, arch_supervoltage, address, prog_data, prog_data_oe,
    program_strobe_n, verify_strobe_n, enable_init_n, pclk, diagnostic_mode_select,
    diagnostic_shift_clock, shadow_serial_input, shadow_to_pipe,
    input dev_data, dev_data_oe, shadow_serial_output);
endinterface : rpp_link_if
`default_nettype wire

// ---- src/rpp_prom.sv ----
// registered prom model: array, architecture byte, pipeline and shadow registers
`timescale 1ns/10ps
`default_nettype none
`include "rpp_map.svh"
module rpp_prom
  import rpp_pkg::*;
#(
  parameter int AW = 13
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  rpp_link_if.prom  link
);
  initial begin
    if (AW < 2 || AW > 16) $error("rpp_prom: AW out of range");
  end

  // power-up stands in for erase; the array survives aresetn
  logic [7:0] mem [0:(1<<AW)-1] = '{default: `RPP_ERASED_BYTE};
  logic [7:0] arch_reg = `RPP_ARCH_ASYNC_OE;
  logic [7:0] init_reg = `RPP_ERASED_BYTE;
  logic [7:0] pipe_reg;
  logic [7:0] shadow_reg;
  logic       oe_reg;
  logic       pgm_q1, pgm_q2, pgm_q3;
  logic       clk_q1, clk_q2, clk_q3;
  logic       dck_q1, dck_q2, dck_q3;
  logic       en_q1, en_q2, en_q3;
  logic       pgm_fall, pclk_rise, diagnostic_shift_clock_rise;
  rpp_arch_e  arch_mode;

  always_ff @(posedge aclk) begin
    pgm_q1 <= link.program_strobe_n;
    pgm_q2 <= pgm_q1;
    pgm_q3 <= pgm_q2;
    clk_q1 <= link.pclk;
    clk_q2 <= clk_q1;
    clk_q3 <= clk_q2;
    dck_q1 <= link.diagnostic_shift_clock;
    dck_q2 <= dck_q1;
    dck_q3 <= dck_q2;
    en_q1  <= link.enable_init_n;
    en_q2  <= en_q1;
    en_q3  <= en_q2;
  end
  assign pgm_fall  = !pgm_q2 && pgm_q3;
  assign pclk_rise = clk_q2 && !clk_q3;
  assign diagnostic_shift_clock_rise = dck_q2 && !dck_q3;

  always_comb begin
    case (arch_reg)
      `RPP_ARCH_SYNC_OE:    arch_mode = RPP_ARCH_SYNC_EN;
      `RPP_ARCH_ASYNC_INIT: arch_mode = RPP_ARCH_ASYNC_INIT;
      default:              arch_mode = RPP_ARCH_ASYNC_EN;
    endcase
  end

  // programming only ors ones in, erased bits stay zero
  always_ff @(posedge aclk) begin
    if (link.supervoltage && pgm_fall && link.verify_strobe_n) begin
      if (link.arch_supervoltage) begin
        if (link.address[0]) init_reg <= init_reg | link.prog_data;
        else arch_reg <= arch_reg | link.prog_data;
      end else begin
        mem[link.address] <= mem[link.address] | link.prog_data;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pipe_reg <= 8'h00;
    end else if (arch_mode == RPP_ARCH_ASYNC_INIT && !en_q2) begin
      pipe_reg <= init_reg;
    end else if (link.shadow_to_pipe && pclk_rise) begin
      pipe_reg <= shadow_reg;
    end else if (pclk_rise && !link.diagnostic_mode_select) begin
      pipe_reg <= mem[link.address];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shadow_reg <= 8'h00;
    end else if (diagnostic_shift_clock_rise && link.diagnostic_mode_select) begin
      // capture takes the complement so the check can tell the options apart
      shadow_reg <= ~pipe_reg;
    end else if (diagnostic_shift_clock_rise) begin
      shadow_reg <= {shadow_reg[6:0], link.shadow_serial_input};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_reg <= 1'b0;
    end else if (link.diagnostic_mode_select && arch_mode != RPP_ARCH_ASYNC_INIT) begin
      oe_reg <= oe_reg;
    end else begin
      case (arch_mode)
        RPP_ARCH_SYNC_EN:    if (pclk_rise) oe_reg <= !en_q2;
        RPP_ARCH_ASYNC_INIT: oe_reg <= 1'b1;
        default:             oe_reg <= !en_q2;
      endcase
    end
  end

  assign link.dev_data = (!link.verify_strobe_n && link.supervoltage)
                         ? mem[link.address] : pipe_reg;
  // under supervoltage the pins belong to the programmer except during verify
  assign link.dev_data_oe = link.supervoltage ? !link.verify_strobe_n : oe_reg;
  assign link.shadow_serial_output = shadow_reg[7];
endmodule : rpp_prom
`default_nettype wire

// ---- src/rpp_programmer.sv ----
// programmer: adaptive byte loop, architecture pulse, enable check, axi4-lite control
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rpp_map.svh"
// Functional notes
// - supervoltage on only inside a delay window
// - set address, data, then 200 us pulse
// - remove data, verify low, compare, release
// - on pass, overprogram pulse four times width
// - on fail, another 200 us pulse, recompare
// - overprogram equals four times summed pulses
// - ten tries, then 8 ms pulse, else reject
// - advance address until whole array done; here until address equals last_reg (reset value all ones)
// - final verify pass over every location; here locations 0 to last_reg
// - architecture uses single 10 ms pulse
// - two extra supervoltage pins pick architecture; here one, arch_supervoltage, with address[0] picking arch_reg or init_reg
// - pulse only after supplies and pins settle
// - enable low, clock, capture complement, reload, clock
// - complement means output enable, true means init
// - async enable drives and floats without clock
// - sync enable acts on rising clock edges
// - blank part behaves as async enable
// - diagnostics freeze enable; outputs follow pipeline
// - per-byte pulse never exceeds 10 ms
// - erased reads zero; one bits program
// - control byte 00, 01, 02 encodings
module rpp_programmer
  import rpp_pkg::*;
#(
  parameter int AW         = 13,
  parameter int PULSE_CYC  = `RPP_PULSE_CYC,
  parameter int ARCH_CYC   = `RPP_ARCH_CYC,
  parameter int LAST_CYC   = `RPP_LAST_CYC,
  parameter int SETTLE_CYC = `RPP_SETTLE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  rpp_link_if.prog         link
);
  initial begin
    if (AW < 2 || AW > 16 || PULSE_CYC < 1 || SETTLE_CYC < 1) $error("rpp_programmer: bad params");
    if (`RPP_OVER_MULT * `RPP_MAX_TRIES * PULSE_CYC > ARCH_CYC) $error("rpp_programmer: pulse sum");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_POWER, S_SETUP, S_PULSE, S_HOLD, S_VERIFY, S_DECIDE,
    S_NEXT, S_FINAL, S_CHK_LO, S_CHK_CAP, S_CHK_XFER, S_CHK_READ, S_DOWN
  } rpp_state_e;

  rpp_state_e    state_reg;
  logic [3:0]    ctrl_reg;
  logic [AW-1:0] addr_reg;
  logic [AW-1:0] last_reg;
  logic [AW-1:0] fail_reg;
  logic [7:0]    data_reg;
  logic [7:0]    ref_reg;
  logic [31:0]   cnt_reg;
  logic [31:0]   sum_reg;
  logic [3:0]    tries_reg;
  logic          over_reg, last_try_reg, final_reg, pass_reg, reject_reg, cfg_oe_reg;
  logic          aw_done, w_done, ar_hit;
  logic [31:0]   aw_q, w_q;
  logic [7:0]    rd_q1, rd_q2, rd_q3;
  logic          busy, go;

  // device data is a pin bus: three stages, accept once the last two agree
  always_ff @(posedge aclk) begin
    rd_q1 <= link.dev_data;
    rd_q2 <= rd_q1;
    rd_q3 <= rd_q2;
  end

  function automatic logic [31:0] dec(input logic [31:0] a);
    dec = {a[31:2], 2'b00};
  endfunction : dec

  assign busy = state_reg != S_IDLE;
  assign s_axi_awready = !aw_done && !s_axi_bvalid;
  assign s_axi_wready  = !w_done && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp   = 2'b00;
  assign s_axi_rresp   = 2'b00;
  assign go = aw_done && w_done && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_done <= 1'b0;
      w_done <= 1'b0;
      aw_q <= 32'h0;
      w_q <= 32'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (go) begin
        aw_done <= 1'b0;
        w_done <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case (dec(s_axi_araddr))
        `RPP_REG_CTRL:   s_axi_rdata <= {28'h0, ctrl_reg};
        `RPP_REG_STATUS: s_axi_rdata <= {28'h0, cfg_oe_reg, reject_reg, pass_reg, busy};
        `RPP_REG_ADDR:   s_axi_rdata <= 32'(fail_reg);
        `RPP_REG_DATA:   s_axi_rdata <= {24'h0, data_reg};
        `RPP_REG_LAST:   s_axi_rdata <= 32'(last_reg);
        default:         s_axi_rdata <= 32'h0;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // start bit self-clears when the sequence takes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 4'h0;
      data_reg <= 8'h00;
      last_reg <= '1;
    end else if (go && !busy) begin
      if (dec(aw_q) == `RPP_REG_CTRL && s_axi_wstrb[0]) ctrl_reg <= w_q[3:0];
      if (dec(aw_q) == `RPP_REG_DATA && s_axi_wstrb[0]) data_reg <= w_q[7:0];
      if (dec(aw_q) == `RPP_REG_LAST) last_reg <= w_q[AW-1:0];
    end else if (state_reg != S_IDLE) begin
      ctrl_reg[`RPP_CTRL_START] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      cnt_reg <= 32'h0;
      sum_reg <= 32'h0;
      tries_reg <= 4'h0;
      addr_reg <= '0;
      fail_reg <= '0;
      ref_reg <= 8'h00;
      {over_reg, last_try_reg, final_reg, pass_reg, reject_reg, cfg_oe_reg} <= 6'h0;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      case (state_reg)
        S_IDLE: if (ctrl_reg[`RPP_CTRL_START]) begin
          state_reg <= S_POWER;
          cnt_reg <= 32'h0;
          addr_reg <= '0;
          {over_reg, last_try_reg, final_reg, pass_reg, reject_reg} <= 5'h0;
          sum_reg <= 32'h0;
          tries_reg <= 4'h0;
        end
        S_POWER: if (cnt_reg >= 32'(SETTLE_CYC)) begin
          cnt_reg <= 32'h0;
          state_reg <= ctrl_reg[`RPP_CTRL_CHECK] ? S_CHK_LO : S_SETUP;
        end
        S_SETUP: if (cnt_reg >= 32'(SETTLE_CYC)) begin
          cnt_reg <= 32'h0;
          state_reg <= final_reg ? S_VERIFY : S_PULSE;
        end
        S_PULSE: if (ctrl_reg[`RPP_CTRL_ARCH] ? cnt_reg >= 32'(ARCH_CYC - 1)
            : over_reg ? (last_try_reg ? cnt_reg >= 32'(LAST_CYC - 1)
              : cnt_reg >= 32'(`RPP_OVER_MULT) * sum_reg - 32'h1)
            : cnt_reg >= 32'(PULSE_CYC - 1)) begin
          cnt_reg <= 32'h0;
          if (!over_reg && !ctrl_reg[`RPP_CTRL_ARCH]) begin
            sum_reg <= sum_reg + 32'(PULSE_CYC);
            tries_reg <= tries_reg + 4'h1;
          end
          state_reg <= S_HOLD;
        end
        S_HOLD: if (cnt_reg >= 32'(SETTLE_CYC)) begin
          cnt_reg <= 32'h0;
          state_reg <= ctrl_reg[`RPP_CTRL_ARCH] ? S_DOWN
                     : (over_reg && !last_try_reg) ? S_NEXT : S_VERIFY;
        end
        // all three sync stages must hold verify data before the first sample
        S_VERIFY: if (cnt_reg >= 32'(2 * SETTLE_CYC + 1)) begin
          cnt_reg <= 32'h0;
          ref_reg <= rd_q3;
          state_reg <= S_DECIDE;
        end
        S_DECIDE: begin
          cnt_reg <= 32'h0;
          if (rd_q3 == ref_reg && ref_reg == data_reg) begin
            if (final_reg) state_reg <= S_NEXT;
            else if (last_try_reg) state_reg <= S_NEXT;
            else begin
              over_reg <= 1'b1;
              state_reg <= S_SETUP;
            end
          end else if (final_reg || last_try_reg) begin
            reject_reg <= 1'b1;
            fail_reg <= addr_reg;
            state_reg <= S_DOWN;
          end else begin
            if (tries_reg == 4'(`RPP_MAX_TRIES)) begin
              over_reg <= 1'b1;
              last_try_reg <= 1'b1;
            end
            state_reg <= S_SETUP;
          end
        end
        S_NEXT: begin
          {over_reg, last_try_reg} <= 2'b00;
          sum_reg <= 32'h0;
          tries_reg <= 4'h0;
          cnt_reg <= 32'h0;
          if (addr_reg == last_reg) begin
            addr_reg <= '0;
            if (final_reg) begin
              pass_reg <= 1'b1;
              state_reg <= S_DOWN;
            end else begin
              final_reg <= 1'b1;
              state_reg <= S_SETUP;
            end
          end else begin
            addr_reg <= addr_reg + 1'b1;
            state_reg <= S_SETUP;
          end
        end
        // pclk rise needs three stages in the prom before capture mode starts
        S_CHK_LO: if (cnt_reg >= 32'(4 * SETTLE_CYC)) begin
          cnt_reg <= 32'h0;
          state_reg <= S_CHK_CAP;
        end
        S_CHK_CAP: if (cnt_reg >= 32'(4 * SETTLE_CYC)) begin
          cnt_reg <= 32'h0;
          ref_reg <= rd_q3;
          state_reg <= S_CHK_XFER;
        end
        S_CHK_XFER: if (cnt_reg >= 32'(4 * SETTLE_CYC)) begin
          cnt_reg <= 32'h0;
          state_reg <= S_CHK_READ;
        end
        // reload lands three edges after pclk, read-back three more
        S_CHK_READ: if (cnt_reg >= 32'(6 * SETTLE_CYC)) begin
          cfg_oe_reg <= rd_q3 == ~ref_reg;
          pass_reg <= 1'b1;
          cnt_reg <= 32'h0;
          state_reg <= S_DOWN;
        end
        S_DOWN: if (cnt_reg >= 32'(SETTLE_CYC)) begin
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // check sequence: pclk pulses in LO (second part) and READ; diag clock in CAP
  always_comb begin
    link.supervoltage = state_reg != S_IDLE && state_reg != S_DOWN && !ctrl_reg[`RPP_CTRL_CHECK];
    link.arch_supervoltage = link.supervoltage && ctrl_reg[`RPP_CTRL_ARCH];
    link.address = addr_reg;
    link.prog_data = data_reg;
    link.prog_data_oe = state_reg == S_SETUP || state_reg == S_PULSE;
    link.program_strobe_n = state_reg != S_PULSE;
    link.verify_strobe_n = !(state_reg == S_VERIFY || state_reg == S_DECIDE);
    link.enable_init_n = !(state_reg == S_CHK_LO || state_reg == S_CHK_CAP
                           || state_reg == S_CHK_XFER || state_reg == S_CHK_READ);
    link.pclk = (state_reg == S_CHK_LO && cnt_reg >= 32'(SETTLE_CYC))
              || (state_reg == S_CHK_READ && cnt_reg < 32'(2 * SETTLE_CYC));
    link.diagnostic_mode_select = state_reg == S_CHK_CAP;
    link.diagnostic_shift_clock = state_reg == S_CHK_CAP && cnt_reg >= 32'(SETTLE_CYC)
                                  && cnt_reg < 32'(2 * SETTLE_CYC);
    link.shadow_to_pipe = state_reg == S_CHK_READ;
    link.shadow_serial_input = 1'b0;
  end
endmodule : rpp_programmer
`default_nettype wire

// ---- verification/rpp_link_chk.sv ----
// concurrent checks on the pins between programmer and prom
`timescale 1ns/10ps
`default_nettype none
module rpp_link_chk #(
  parameter int AW        = 13,
  parameter int PULSE_CYC = 4,
  parameter int ARCH_CYC  = 200,
  parameter int LAST_CYC  = 20
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          supervoltage,
  input  wire logic          arch_supervoltage,
  input  wire logic [AW-1:0] address,
  input  wire logic          prog_data_oe,
  input  wire logic          dev_data_oe,
  input  wire logic          program_strobe_n,
  input  wire logic          verify_strobe_n
);
  localparam logic [15:0] P_W = PULSE_CYC[15:0];
  localparam logic [15:0] A_W = ARCH_CYC[15:0];
  localparam logic [15:0] L_W = LAST_CYC[15:0];
  localparam logic [15:0] T_W = 16'(10 * PULSE_CYC);
  logic [15:0]   low_cnt_reg;
  logic [15:0]   sum_reg;
  logic [AW-1:0] addr_reg;
  logic          arch_reg;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // low cycles of the strobe, still whole at the rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn || program_strobe_n) low_cnt_reg <= 16'h0;
    else low_cnt_reg <= low_cnt_reg + 16'h1;
  end
  always_ff @(posedge aclk) begin
    arch_reg <= aresetn && !program_strobe_n && (arch_reg || arch_supervoltage);
  end
  always_ff @(posedge aclk) begin
    addr_reg <= address;
  end
  // initial pulses summed per location; supply drop ends a run
  always_ff @(posedge aclk) begin
    if (!aresetn || !supervoltage || address != addr_reg) sum_reg <= 16'h0;
    else if (program_strobe_n && low_cnt_reg == P_W && !arch_reg) sum_reg <= sum_reg + P_W;
  end
  supply_first_a: assert property ($fell(program_strobe_n) |-> $past(supervoltage))
    else $error("strobe fell before supply was up");
  supply_kept_a: assert property ($rose(program_strobe_n) |-> supervoltage)
    else $error("supply gone before strobe ended");
  arch_pins_a: assert property (arch_supervoltage |-> supervoltage)
    else $error("extra pins high without main supply");
  data_in_pulse_a: assert property (!program_strobe_n |-> prog_data_oe)
    else $error("strobe low with data not driven");
  data_off_verify_a: assert property (!verify_strobe_n |-> !prog_data_oe && program_strobe_n)
    else $error("data driven or strobe low during verify");
  no_fight_a: assert property (!(prog_data_oe && dev_data_oe))
    else $error("both ends drive the data pins");
  over_width_a: assert property (($rose(program_strobe_n) && !arch_reg && low_cnt_reg != P_W) |->
    (low_cnt_reg == {sum_reg[13:0], 2'b00} && sum_reg != 16'h0) || (low_cnt_reg == L_W && sum_reg == T_W))
    else $error("overprogram pulse width wrong");
  retry_cap_a: assert property (sum_reg <= T_W)
    else $error("more than ten initial pulses");
  max_pulse_a: assert property (low_cnt_reg <= A_W)
    else $error("program pulse too long");
  arch_pulse_a: assert property (($rose(program_strobe_n) && arch_reg) |-> low_cnt_reg == A_W)
    else $error("architecture pulse width wrong");
endmodule : rpp_link_chk
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench: both link ends, driven through the controller registers
`timescale 1ns/10ps
`default_nettype none
`include "rpp_map.svh"
module testbench;
  localparam int AW = 13;
  localparam int PW = 4;
  localparam int AC = 200;
  localparam int LC = 20;
  typedef struct {logic [31:0] e; logic [31:0] m;} rpp_note_s;
  logic        aclk;
  logic        aresetn;
  logic [31:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [31:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [31:0] last_rd;
  logic [7:0]  d1;
  logic [7:0]  code_tab [2] = '{`RPP_ARCH_ASYNC_OE, `RPP_ARCH_ASYNC_INIT};
  integer      seed;
  int          bad_count = 0;
  int          check_count = 0;
  rpp_note_s   q [$];
  rpp_note_s   n;
  rpp_link_if #(.AW(AW)) link ();
  rpp_prom #(.AW(AW)) rpp_prom_i (.aclk, .aresetn, .link(link.prom));
  rpp_programmer #(.AW(AW), .PULSE_CYC(PW), .ARCH_CYC(AC), .LAST_CYC(LC), .SETTLE_CYC(1))
    rpp_programmer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(link.prog));
  rpp_link_chk #(.AW(AW), .PULSE_CYC(PW), .ARCH_CYC(AC), .LAST_CYC(LC)) rpp_link_chk_i (
    .aclk, .aresetn, .supervoltage(link.supervoltage),
    .arch_supervoltage(link.arch_supervoltage), .address(link.address),
    .prog_data_oe(link.prog_data_oe), .dev_data_oe(link.dev_data_oe),
    .program_strobe_n(link.program_strobe_n), .verify_strobe_n(link.verify_strobe_n));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic results();
    $display("errors %0d checks %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bit ad;
    bit dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr
  // mask zero marks a polling read that is noted but not compared
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    q.push_back('{e, m});
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    last_rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wait_idle();
    do rd(`RPP_REG_STATUS, 32'h0, 32'h0); while (last_rd[`RPP_ST_BUSY] !== 1'b0);
  endtask : wait_idle
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      if (n.m != 32'h0) begin
        check_count++;
        if ((((s_axi_rdata ^ n.e) & n.m) !== 32'h0) || s_axi_rresp !== 2'b00) begin
          bad_count++;
          $display("mismatch t=%0t exp=%h got=%h", $time, n.e & n.m, s_axi_rdata & n.m);
        end
      end
    end
  end
  // whole run is under a thousand cycles; this bound only catches a hang
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    results();
  end
  initial begin
    seed = 95;
    aresetn = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RPP_REG_STATUS, 32'h0, 32'h7);
    rd(`RPP_REG_LAST, 32'h1fff, 32'h1fff);
    rd(32'h0000_0040, 32'h0, 32'hffff_ffff);
    d1 = 8'($random(seed)) | 8'h01;
    wr(`RPP_REG_LAST, 32'h2);
    wr(`RPP_REG_DATA, {24'h0, d1});
    wr(`RPP_REG_CTRL, 32'h1);
    // refused while busy, else the run would program ~d1 throughout and the reject run below would pass
    wr(`RPP_REG_DATA, {24'h0, ~d1});
    wait_idle();
    rd(`RPP_REG_STATUS, 32'h2, 32'h7);
    wr(`RPP_REG_DATA, {24'h0, ~d1});
    wr(`RPP_REG_CTRL, 32'h1);
    wait_idle();
    rd(`RPP_REG_STATUS, 32'h4, 32'h7);
    rd(`RPP_REG_ADDR, 32'h0, 32'h1fff);
    for (int i = 0; i < 2; i++) begin
      wr(`RPP_REG_DATA, {24'h0, code_tab[i]});
      wr(`RPP_REG_CTRL, 32'h3);
      wait_idle();
      wr(`RPP_REG_CTRL, 32'h9);
      wait_idle();
      rd(`RPP_REG_STATUS, {28'h0, (i == 0), 3'h0}, 32'h9);
    end
    results();
  end
endmodule : testbench
`default_nettype wire
